// File: inc/sspc_consts.svh
// timing counts and reset values of the start-up sequencer
`ifndef SSPC_CONSTS_SVH
`define SSPC_CONSTS_SVH
`define SSPC_CLK_MHZ 100
`define SSPC_SYNC_STEP_NS 100
`define SSPC_SYNC_STEP_CYC ((`SSPC_SYNC_STEP_NS * `SSPC_CLK_MHZ + 999) / 1000)
`define SSPC_LOCK_WAIT_US 200
`define SSPC_LOCK_WAIT_CYC (`SSPC_LOCK_WAIT_US * `SSPC_CLK_MHZ)
`define SSPC_I2C_ADDR_RST 7'h09
`define SSPC_DECODE_SEL_RST 4'h4
`define SSPC_SRC_APLL 4'h0
`define SSPC_SRC_DPLL 4'h1
`define SSPC_SRC_REF_LOS 4'h2
`define SSPC_SRC_XO_LOS 4'h3
`define SSPC_SRC_REF_ACT 4'h4
`define SSPC_SRC_REF_INV 4'h5
`define SSPC_SRC_INT 4'h6
`define SSPC_SRC_READY 4'h7
`define SSPC_SRC_LOW 4'h8
`define SSPC_SRC_HIGH 4'h9
`define SSPC_SPI_RW_BIT 7
`define SSPC_PAGE_OFFSET 8'h7C
`define SSPC_STRAP_LOCK 0
`define SSPC_STRAP_GATE 1
`define SSPC_STRAP_SDA 2
`define SSPC_STRAP_SDO 3
`define SSPC_STRAP_CS 4
`define SSPC_STRAP_SCL 5
`endif

// File: inc/sspc_pkg.sv
// types of the start-up sequencer
package sspc_pkg;
	typedef enum logic [3:0] {
		SSPC_OTP_LOAD,
		SSPC_VCO_CAL,
		SSPC_GATE,
		SSPC_RELEASE,
		SSPC_UNGATE,
		SSPC_APLL_WAIT,
		SSPC_DPLL_ACQ,
		SSPC_RUN
	} sspc_state_type;
	typedef struct packed {
		sspc_state_type state;
		logic [31:0] count;
		logic [5:0] straps;
		logic strap_taken;
		logic vco_gate;
		logic [2:0] div_rst;
		logic mon_en;
		logic loop_start;
		logic seq_done;
		logic acq_filter;
		logic lock_pad_o;
		logic lock_pad_oe;
		logic sdo_pad_o;
		logic sdo_pad_oe;
		logic out_gate;
		logic [1:0] cfg_index;
		logic [6:0] i2c_addr;
		logic serial_active;
		logic ready;
	} sspc_regs_type;
endpackage

// File: tb/sspc_board.sv
// board straps, pad wires and pll lock behaviour around the sequencer
`default_nettype none
module sspc_board (
	input wire logic core_clk,
	input wire logic [5:0] pulls,
	input wire logic [7:0] lock_delay,
	input wire logic status_pin_a_out,
	input wire logic status_pin_a_oe,
	input wire logic serial_out_out,
	input wire logic serial_out_oe,
	input wire logic vco_clock_gate,
	input wire logic [2:0] divider_reset,
	input wire logic tracking_loop_start,
	output logic [5:0] pins,
	output logic apll_lock,
	output logic dpll_lock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ac = 8'h00;
	logic [7:0] dc = 8'h00;
	// a released pad falls back to its strap resistor
	assign pins = {pulls[5:4], serial_out_oe ? serial_out_out : pulls[3], pulls[2:1],
		status_pin_a_oe ? status_pin_a_out : pulls[0]};
	always @(posedge core_clk)
	begin
		// syncing the crystal-fed loop costs lock, then the dpll follows
		if (vco_clock_gate || divider_reset != 3'h0)
			ac <= 8'h00;
		else if (ac < lock_delay)
			ac <= ac + 8'h01;
		if (!tracking_loop_start || !apll_lock)
			dc <= 8'h00;
		else if (dc < lock_delay)
			dc <= dc + 8'h01;
	end
	assign apll_lock = ac >= lock_delay;
	assign dpll_lock = dc >= lock_delay;
endmodule
`default_nettype wire

// File: tb/sspc_seq_assertions.sv
// concurrent checks on the start-up sequencer ports
`default_nettype none
module sspc_seq_assertions #(
	parameter int unsigned LOCK_WAIT_CYC = 4
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic otp_load_done,
	input wire logic apll_lock,
	input wire logic dpll_lock,
	input wire logic jitter_attenuator_mode,
	input wire logic divider_align_cmd,
	input wire logic pll_restart_cmd,
	input wire logic status_pin_a_oe,
	input wire logic serial_out_oe,
	input wire logic serial_port_active,
	input wire logic device_ready,
	input wire logic vco_clock_gate,
	input wire logic [2:0] divider_reset,
	input wire logic monitor_enable,
	input wire logic tracking_loop_start,
	input wire logic acq_filter_select,
	input wire logic clock_outputs_enable,
	input wire logic sequence_complete,
	input wire logic [5:0] strap_levels
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_port_after_load: assert property ($rose(serial_port_active) |-> $past(otp_load_done))
		else $error("port woke early");
	a_ready_after_port: assert property (device_ready == ($past(otp_load_done) && serial_port_active))
		else $error("ready late");
	a_pin_a_quiet: assert property (!serial_port_active |-> !status_pin_a_oe)
		else $error("pin a driven early");
	a_sdo_quiet: assert property (!serial_port_active |-> !serial_out_oe)
		else $error("sdo driven early");
	a_outputs_held: assert property (!sequence_complete |-> !clock_outputs_enable)
		else $error("outputs early");
	a_gate_resets: assert property ($rose(vco_clock_gate) |-> (divider_reset == 3'h7)[*8])
		else $error("resets not held");
	a_ungate_clean: assert property ($fell(vco_clock_gate) |-> divider_reset == 3'h0)
		else $error("ungate before release");
	a_monitor_lock: assert property ($rose(monitor_enable) |-> $past(apll_lock))
		else $error("monitor before lock");
	a_jitter_done: assert property ($rose(sequence_complete) && jitter_attenuator_mode
		|-> $past(dpll_lock)) else $error("done before dpll lock");
	a_restart_drop: assert property (serial_port_active && pll_restart_cmd
		|=> !sequence_complete && !clock_outputs_enable) else $error("restart ignored");
	a_align_drop: assert property (sequence_complete && divider_align_cmd
		|=> !clock_outputs_enable) else $error("align ignored");
	a_acq_window: assert property (acq_filter_select |-> tracking_loop_start
		&& !sequence_complete) else $error("acquire filter misplaced");
	a_strap_hold: assert property (serial_port_active |-> $stable(strap_levels))
		else $error("straps moved");
	c_done: cover property ($rose(sequence_complete));
	c_track: cover property ($rose(tracking_loop_start));
	c_drop: cover property ($fell(sequence_complete));
endmodule
bind sspc_sequencer sspc_seq_assertions #(.LOCK_WAIT_CYC(LOCK_WAIT_CYC)) u_chk (.*);
`default_nettype wire

// File: tb/tb_sspc_sequencer.sv
// self-checking bench of the start-up sequencer
`default_nettype none
module tb_sspc_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LW = 4;
	localparam logic [15:0] DTAB [16] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1043, 16'h3041,
		16'h3140, 16'h2576, 16'h4031, 16'h4130, 16'h4310, 16'h4230, 16'h4512, 16'h4215,
		16'h2014, 16'h2310};
	logic core_clk, rst_b, otp_load_done, vco_cal_done, ref_los, xo_los, ref_activity;
	logic ref_invalid, ref_qualified, chip_interrupt, jitter_attenuator_mode;
	logic divider_align_cmd, pll_restart_cmd, acquire_filter_switch, status_pin_a_invert;
	logic status_pin_a_float, status_pin_a_opendrain, serial_out_invert, serial_out_float;
	logic serial_out_opendrain, four_wire_spi, spi_read_data, spi_read_oe;
	logic output_gate_enable, output_gate_invert, status_pin_a_out, status_pin_a_oe;
	logic serial_out_out, serial_out_oe, serial_port_active, device_ready, vco_clock_gate;
	logic monitor_enable, tracking_loop_start, acq_filter_select, clock_outputs_enable;
	logic sequence_complete, apll_lock, dpll_lock, seen_acq;
	logic [3:0] status_pin_a_source, serial_out_source, strap_decode_select;
	logic [6:0] bus_target_address, i2c_target_address;
	logic [2:0] divider_reset;
	logic [5:0] strap_levels, pulls, pins;
	logic [1:0] config_index;
	logic [7:0] lock_delay;
	logic [9:0] cv;
	logic [31:0] r;
	logic [31:0] seed = 32'h2A;
	int num_errors = 0;
	int num_checks = 0;
	wire logic status_pin_a_in = pins[0];
	wire logic output_gate_pin = pins[1];
	wire logic serial_data_pin = pins[2];
	wire logic serial_out_in = pins[3];
	wire logic chip_select_pin = pins[4];
	wire logic serial_clock_pin = pins[5];
	sspc_sequencer #(.LOCK_WAIT_CYC(LW)) u_dut (.*);
	sspc_board u_board (.*);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected pad level from condition and invert, float, open-drain bits
	function automatic logic pexp(input logic c, input logic [2:0] m, input logic p);
		logic v;
		v = c ^ m[2];
		return (!m[1] && (!m[0] || !v)) ? v : p;
	endfunction
	function automatic logic [3:0] dec(input logic [3:0] s);
		logic [7:0] v;
		logic [15:0] t;
		v = {bus_target_address[1:0], pulls};
		t = DTAB[s];
		if (s < 4'h4)
			return {s[1:0], bus_target_address[1:0]};
		return {v[t[14:12]], v[t[10:8]], v[t[6:4]], v[t[2:0]]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (sequence_complete !== 1'b1 && n < 600)
		begin
			seen_acq |= acq_filter_select;
			tick(1);
			n++;
		end
		check(n < 600, 1'b1, "no completion");
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		#50000;
		num_errors++;
		final_report();
	end
	initial
	begin
		{rst_b, otp_load_done, vco_cal_done, ref_los, xo_los, ref_activity, ref_invalid} = '0;
		{ref_qualified, chip_interrupt, jitter_attenuator_mode, divider_align_cmd} = '0;
		{pll_restart_cmd, acquire_filter_switch, four_wire_spi, spi_read_data} = '0;
		{status_pin_a_invert, status_pin_a_float, status_pin_a_opendrain} = '0;
		{serial_out_invert, serial_out_float, serial_out_opendrain, spi_read_oe} = '0;
		{output_gate_enable, output_gate_invert, seen_acq} = '0;
		{status_pin_a_source, serial_out_source} = '0;
		lock_delay = 8'h06;
		r = rnd();
		pulls = r[5:0];
		bus_target_address = r[12:6];
		strap_decode_select = 4'h4;
		tick(2);
		check(i2c_target_address, 7'h09, "addr reset");
		check(clock_outputs_enable, 1'b0, "outputs reset");
		tick(2);
		rst_b = 1'b1;
		tick(4);
		check(strap_levels, pulls, "straps");
		for (int s = 0; s < 16; s++)
		begin
			strap_decode_select = 4'(s);
			tick(2);
			check({config_index, i2c_target_address[1:0]}, dec(4'(s)), "decode");
		end
		$display("test straps done");
		check({serial_port_active, status_pin_a_oe, serial_out_oe}, 3'h0, "idle");
		otp_load_done = 1'b1;
		tick(1);
		check({serial_port_active, device_ready}, 2'b11, "port");
		tick(1);
		check(device_ready, 1'b1, "ready");
		vco_cal_done = 1'b1;
		wait_done();
		check({monitor_enable, clock_outputs_enable}, 2'b11, "synth run");
		output_gate_enable = 1'b1;
		for (int g = 0; g < 4; g++)
		begin
			pulls[1] = g[0];
			output_gate_invert = g[1];
			tick(4);
			check(clock_outputs_enable, g[0] ^ g[1], "gate");
		end
		output_gate_enable = 1'b0;
		$display("test sequence done");
		for (int c = 0; c < 20; c++)
		begin
			r = rnd();
			status_pin_a_source = 4'(c / 2);
			serial_out_source = 4'(9 - c / 2);
			{status_pin_a_invert, status_pin_a_float, status_pin_a_opendrain} = r[2:0];
			{serial_out_invert, serial_out_float, serial_out_opendrain} = r[5:3];
			{ref_los, xo_los, ref_activity, ref_invalid, chip_interrupt} = r[10:6];
			pulls[0] = r[11];
			pulls[3] = r[12];
			tick(3);
			cv = {3'h5, chip_interrupt, ref_invalid, ref_activity, xo_los, ref_los, dpll_lock,
				apll_lock};
			check(pins[0], pexp(cv[c / 2], r[2:0], r[11]), "pin a");
			check(pins[3], pexp(cv[9 - c / 2], r[5:3], r[12]), "sdo");
		end
		four_wire_spi = 1'b1;
		{serial_out_invert, serial_out_float, serial_out_opendrain} = 3'h0;
		spi_read_oe = 1'b1;
		for (int d = 0; d < 2; d++)
		begin
			spi_read_data = d[0];
			tick(3);
			check(pins[3], d[0], "spi data");
		end
		{four_wire_spi, spi_read_oe} = 2'h0;
		$display("test pins done");
		{jitter_attenuator_mode, ref_qualified, acquire_filter_switch} = 3'h7;
		lock_delay = 8'h14;
		pll_restart_cmd = 1'b1;
		tick(1);
		pll_restart_cmd = 1'b0;
		check({sequence_complete, clock_outputs_enable}, 2'h0, "restart");
		wait_done();
		check({seen_acq, clock_outputs_enable}, 2'h3, "jitter run");
		lock_delay = 8'h03;
		divider_align_cmd = 1'b1;
		tick(1);
		divider_align_cmd = 1'b0;
		check(clock_outputs_enable, 1'b0, "align");
		wait_done();
		rst_b = 1'b0;
		tick(2);
		check({sequence_complete, i2c_target_address}, 8'h09, "second reset");
		tick(2);
		rst_b = 1'b1;
		tick(3);
		check(strap_levels, pulls, "straps again");
		$display("test commands done");
		final_report();
	end
endmodule
`default_nettype wire

// File: verilog/sspc_sequencer.sv
// start-up sequencer, status pins and strap decode
// Notes on behaviour
// - spi first byte msb: 1 read, 0 write
// - status pin a shows selected condition
// - ready means otp loaded and port active
// - pin a polarity, pulls, float, open-drain
// - pin a driver off until otp loaded
// - serial-out is data in four-wire spi
// - serial-out status uses own pin controls
// - serial-out driver off until otp loaded
// - output gate pin, polarity and pulls
// - gate, release divider resets, then ungate
// - monitors enabled after analog pll lock
// - synth mode: outputs on after apll lock
// - jitter mode: acquire then dpll lock
// - align command reruns sync, outputs off
// - restart command reruns from vco calibration
// - straps captured at reset release
// - select 0-3: direct index, register address
// - select 4-F: index from straps; address from straps too, except at 7 where it stays the register address
// - crystal apll sync drops and regains lock
// - acquire filter set while acquiring
// - serial interfaces idle until otp loaded
// - i2c target address resets to 0x09
`include "sspc_consts.svh"
`default_nettype none
module sspc_sequencer
	import sspc_pkg::*;
#(
	parameter int unsigned LOCK_WAIT_CYC = `SSPC_LOCK_WAIT_CYC
)
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic otp_load_done,
	input wire logic vco_cal_done,
	input wire logic apll_lock,
	input wire logic dpll_lock,
	input wire logic ref_los,
	input wire logic xo_los,
	input wire logic ref_activity,
	input wire logic ref_invalid,
	input wire logic ref_qualified,
	input wire logic chip_interrupt,
	input wire logic jitter_attenuator_mode,
	input wire logic divider_align_cmd,
	input wire logic pll_restart_cmd,
	input wire logic acquire_filter_switch,
	input wire logic [3:0] status_pin_a_source,
	input wire logic status_pin_a_invert,
	input wire logic status_pin_a_float,
	input wire logic status_pin_a_opendrain,
	input wire logic [3:0] serial_out_source,
	input wire logic serial_out_invert,
	input wire logic serial_out_float,
	input wire logic serial_out_opendrain,
	input wire logic four_wire_spi,
	input wire logic spi_read_data,
	input wire logic spi_read_oe,
	input wire logic output_gate_enable,
	input wire logic output_gate_invert,
	input wire logic [3:0] strap_decode_select,
	input wire logic [6:0] bus_target_address,
	input wire logic status_pin_a_in,
	input wire logic output_gate_pin,
	input wire logic serial_data_pin,
	input wire logic serial_out_in,
	input wire logic chip_select_pin,
	input wire logic serial_clock_pin,
	output logic status_pin_a_out,
	output logic status_pin_a_oe,
	output logic serial_out_out,
	output logic serial_out_oe,
	output logic serial_port_active,
	output logic device_ready,
	output logic vco_clock_gate,
	output logic [2:0] divider_reset,
	output logic monitor_enable,
	output logic tracking_loop_start,
	output logic acq_filter_select,
	output logic clock_outputs_enable,
	output logic sequence_complete,
	output logic [5:0] strap_levels,
	output logic [1:0] config_index,
	output logic [6:0] i2c_target_address
);
	if (LOCK_WAIT_CYC < 1)
	begin : g_lock_wait_check
		$error("lock wait must be at least one cycle");
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic [5:0] pin_raw;
	assign pin_raw = {serial_clock_pin, chip_select_pin, serial_out_in, serial_data_pin,
		output_gate_pin, status_pin_a_in};
	// runs through reset so that the strap levels are already valid at release
	always_ff @(posedge core_clk)
	begin
		pin_meta <= pin_raw;
		pin_sync <= pin_meta;
	end

	////////////////////////////////////////////////////////////////////////////////
	// condition selection shared by both status pins
	function automatic logic pick_source(input logic [3:0] sel, input logic [7:0] cond);
		logic v;
		v = 1'b0;
		case (sel)
			`SSPC_SRC_APLL: v = cond[0];
			`SSPC_SRC_DPLL: v = cond[1];
			`SSPC_SRC_REF_LOS: v = cond[2];
			`SSPC_SRC_XO_LOS: v = cond[3];
			`SSPC_SRC_REF_ACT: v = cond[4];
			`SSPC_SRC_REF_INV: v = cond[5];
			`SSPC_SRC_INT: v = cond[6];
			`SSPC_SRC_READY: v = cond[7];
			`SSPC_SRC_LOW: v = 1'b0;
			`SSPC_SRC_HIGH: v = 1'b1;
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	// open-drain drives only the low level; float releases the pin
	function automatic logic [1:0] pad_drive(input logic lvl, input logic inv,
		input logic flt, input logic od, input logic allowed);
		logic o;
		logic oe;
		o = lvl ^ inv;
		oe = allowed && !flt && (!od || !o);
		return {o, oe};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state
	sspc_regs_type r;
	sspc_regs_type next_r;
	logic [7:0] cond;
	logic [1:0] lock_pad;
	logic [1:0] sdo_pad;
	logic cmd_align;
	logic cmd_restart;

	assign cond = {r.ready, chip_interrupt, ref_invalid, ref_activity, xo_los, ref_los,
		dpll_lock, apll_lock};
	assign cmd_align = divider_align_cmd && r.serial_active;
	assign cmd_restart = pll_restart_cmd && r.serial_active;

	always_comb
	begin
		next_r = r;
		next_r.count = r.count + 32'h00000001;
		if (!r.strap_taken)
		begin
			next_r.straps = pin_sync;
			next_r.strap_taken = 1'b1;
		end
		unique case (r.state)
			SSPC_OTP_LOAD:
			begin
				if (otp_load_done && r.strap_taken)
				begin
					next_r.serial_active = 1'b1;
					next_r.state = SSPC_VCO_CAL;
				end
			end
			SSPC_VCO_CAL:
			begin
				if (vco_cal_done)
				begin
					next_r.state = SSPC_GATE;
					next_r.count = 32'h00000000;
				end
			end
			SSPC_GATE:
			begin
				next_r.vco_gate = 1'b1;
				next_r.div_rst = 3'h7;
				if (r.count >= `SSPC_SYNC_STEP_CYC)
				begin
					next_r.state = SSPC_RELEASE;
					next_r.count = 32'h00000000;
				end
			end
			SSPC_RELEASE:
			begin
				next_r.div_rst = 3'h0;
				if (r.count >= `SSPC_SYNC_STEP_CYC)
				begin
					next_r.state = SSPC_UNGATE;
					next_r.count = 32'h00000000;
				end
			end
			SSPC_UNGATE:
			begin
				next_r.vco_gate = 1'b0;
				next_r.state = SSPC_APLL_WAIT;
				next_r.count = 32'h00000000;
			end
			SSPC_APLL_WAIT:
			begin
				// apll loses lock after sync; hold off until lock after the settle time
				if (apll_lock && r.count >= 32'(LOCK_WAIT_CYC))
				begin
					next_r.mon_en = 1'b1;
					if (jitter_attenuator_mode)
						next_r.state = SSPC_DPLL_ACQ;
					else
					begin
						next_r.state = SSPC_RUN;
						next_r.seq_done = 1'b1;
					end
				end
			end
			SSPC_DPLL_ACQ:
			begin
				if (ref_qualified)
					next_r.loop_start = 1'b1;
				if (r.loop_start && dpll_lock && r.count >= 32'(LOCK_WAIT_CYC))
				begin
					next_r.state = SSPC_RUN;
					next_r.seq_done = 1'b1;
				end
			end
			SSPC_RUN:
			begin
			end
		endcase
		if (cmd_restart && r.state != SSPC_OTP_LOAD)
		begin
			next_r.state = SSPC_VCO_CAL;
			next_r.seq_done = 1'b0;
			next_r.mon_en = 1'b0;
			next_r.loop_start = 1'b0;
			next_r.vco_gate = 1'b0;
			next_r.div_rst = 3'h0;
		end
		else if (cmd_align && r.state == SSPC_RUN)
		begin
			next_r.state = SSPC_GATE;
			next_r.count = 32'h00000000;
			next_r.seq_done = 1'b0;
			next_r.loop_start = 1'b0;
		end
		next_r.acq_filter = acquire_filter_switch && next_r.loop_start && !next_r.seq_done;
		next_r.out_gate = next_r.seq_done && (!output_gate_enable ||
			(pin_sync[`SSPC_STRAP_GATE] ^ output_gate_invert));
		next_r.ready = otp_load_done && next_r.serial_active;
		lock_pad = pad_drive(pick_source(status_pin_a_source, cond), status_pin_a_invert,
			status_pin_a_float, status_pin_a_opendrain, r.serial_active);
		next_r.lock_pad_o = lock_pad[1];
		next_r.lock_pad_oe = lock_pad[0];
		sdo_pad = pad_drive(pick_source(serial_out_source, cond), serial_out_invert,
			serial_out_float, serial_out_opendrain, r.serial_active);
		if (four_wire_spi)
		begin
			next_r.sdo_pad_o = spi_read_data;
			next_r.sdo_pad_oe = spi_read_oe && r.serial_active;
		end
		else
		begin
			next_r.sdo_pad_o = sdo_pad[1];
			next_r.sdo_pad_oe = sdo_pad[0];
		end
		if (strap_decode_select <= 4'h3)
		begin
			next_r.cfg_index = strap_decode_select[1:0];
			next_r.i2c_addr = bus_target_address;
		end
		else
		begin
			next_r.i2c_addr = bus_target_address;
			case (strap_decode_select)
				4'h4:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_GATE], r.straps[`SSPC_STRAP_LOCK]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_CS], r.straps[`SSPC_STRAP_SDO]};
				end
				4'h5:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_SDO], r.straps[`SSPC_STRAP_LOCK]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_CS], r.straps[`SSPC_STRAP_GATE]};
				end
				4'h6:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_SDO], r.straps[`SSPC_STRAP_GATE]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_CS], r.straps[`SSPC_STRAP_LOCK]};
				end
				4'h7:
					next_r.cfg_index = {r.straps[`SSPC_STRAP_SDA], r.straps[`SSPC_STRAP_SCL]};
				4'h8:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_CS], r.straps[`SSPC_STRAP_LOCK]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_SDO], r.straps[`SSPC_STRAP_GATE]};
				end
				4'h9:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_CS], r.straps[`SSPC_STRAP_GATE]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_SDO], r.straps[`SSPC_STRAP_LOCK]};
				end
				4'hA:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_CS], r.straps[`SSPC_STRAP_SDO]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_GATE], r.straps[`SSPC_STRAP_LOCK]};
				end
				4'hB:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_CS], r.straps[`SSPC_STRAP_SDA]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_SDO], r.straps[`SSPC_STRAP_LOCK]};
				end
				4'hC:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_CS], r.straps[`SSPC_STRAP_SCL]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_GATE], r.straps[`SSPC_STRAP_SDA]};
				end
				4'hD:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_CS], r.straps[`SSPC_STRAP_SDA]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_GATE], r.straps[`SSPC_STRAP_SCL]};
				end
				4'hE:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_SDA], r.straps[`SSPC_STRAP_LOCK]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_GATE], r.straps[`SSPC_STRAP_CS]};
				end
				default:
				begin
					next_r.cfg_index = {r.straps[`SSPC_STRAP_SDA], r.straps[`SSPC_STRAP_SDO]};
					next_r.i2c_addr[1:0] = {r.straps[`SSPC_STRAP_GATE], r.straps[`SSPC_STRAP_LOCK]};
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			r <= '0;
			r.state <= SSPC_OTP_LOAD;
			r.i2c_addr <= `SSPC_I2C_ADDR_RST;
		end
		else
			r <= next_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign status_pin_a_out = r.lock_pad_o;
	assign status_pin_a_oe = r.lock_pad_oe;
	assign serial_out_out = r.sdo_pad_o;
	assign serial_out_oe = r.sdo_pad_oe;
	assign serial_port_active = r.serial_active;
	assign device_ready = r.ready;
	assign vco_clock_gate = r.vco_gate;
	assign divider_reset = r.div_rst;
	assign monitor_enable = r.mon_en;
	assign tracking_loop_start = r.loop_start;
	assign acq_filter_select = r.acq_filter;
	assign clock_outputs_enable = r.out_gate;
	assign sequence_complete = r.seq_done;
	assign strap_levels = r.straps;
	assign config_index = r.cfg_index;
	assign i2c_target_address = r.i2c_addr;
endmodule
`default_nettype wire
